/* File: rtl/ptl_pkg.sv */
package ptl_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_PT_SOURCE   = 4'h0;  // pre-torque source select
  localparam logic [3:0] ADDR_HOLD        = 4'h1;  // feedforward_hold_param
  localparam logic [3:0] ADDR_STRB_SRC    = 4'h2;  // strobe_source_param
  localparam logic [3:0] ADDR_POL_CHECK   = 4'h3;  // polarity_check_param
  localparam logic [3:0] ADDR_STATUS      = 4'h4;  // latch status, read only
  localparam logic [3:0] ADDR_HELD_VALUE  = 4'h5;  // held feedforward, read only
  localparam logic [3:0] ADDR_SPEED_OUT   = 4'h6;  // qualified speed, read only

  // ---------------------------------------------------------------
  // field codes
  // ---------------------------------------------------------------
  localparam logic [1:0] PT_SRC_NONE      = 2'h0;
  localparam logic [1:0] PT_SRC_ANALOG    = 2'h1;
  localparam logic [1:0] PT_SRC_SERIAL    = 2'h2;
  localparam logic       HOLD_PASS        = 1'h0;
  localparam logic       HOLD_LATCHED     = 1'h1;
  localparam logic [1:0] STRB_TERMINAL    = 2'h1;
  localparam logic [1:0] STRB_SERIAL      = 2'h2;
  localparam logic       POL_CHECK_OFF    = 1'h0;
  localparam logic       POL_CHECK_ON     = 1'h1;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] RST_PT_SOURCE    = PT_SRC_NONE;
  localparam logic       RST_HOLD         = HOLD_PASS;
  localparam logic [1:0] RST_STRB_SRC     = STRB_TERMINAL;
  localparam logic       RST_POL_CHECK    = POL_CHECK_OFF;

  // status bit positions
  localparam int STAT_FULL_BIT = 0;
  localparam int STAT_HOLD_BIT = 1;

  typedef enum logic [1:0] {
    PTL_EMPTY    = 2'b00,
    PTL_FULL     = 2'b01,
    PTL_CONSUMED = 2'b10
  } ptl_latch_e;
endpackage : ptl_pkg

/* File: rtl/ptl_sync2.sv */
`timescale 1ns/1ns
`default_nettype none
module ptl_sync2 #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst_b,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d_in,
  output var  logic [W-1:0] q_out
);
  logic [W-1:0] meta_reg;

  // ---------------------------------------------------------------
  // two-stage synchroniser, per bit
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      // first stage only feeds the second
      always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          meta_reg[gi] <= 1'b0;
          q_out[gi]    <= 1'b0;
        end else if (clk_en) begin
          meta_reg[gi] <= d_in[gi];
          q_out[gi]    <= meta_reg[gi];
        end
      end
    end
  endgenerate
endmodule : ptl_sync2
`default_nettype wire

/* File: rtl/ptl_pretorque_latch_dir_confirm.sv */
// Summary of operation
// - a hold setting picks pass-through (0) or latched (1) feedforward.
// - with no pre-torque source chosen the hold setting is ignored.
// - in latched mode the value is captured only on a rising strobe edge.
// - channel changes outside the strobe edge leave the captured value alone.
// - the strobe source setting only counts in latched mode.
// - the strobe comes from a terminal input (1) or the serial channel (2).
// - with the latch full, the regulator takes the held value when regulator release rises with no strobe edge in the same cycle.
// - once consumed, the latch and held value are cleared.
// - a polarity check enable (1 on, 0 off) guards the initial speed command.
// - check on, run up true with run down false and a positive command passes unchanged.
// - check on, run down true with run up false and a negative command passes unchanged.
// - check on, up with negative or down with positive forces zero.
// - pre-torque source is none (0), analog (1) or serial (2).
`timescale 1ns/1ns
`default_nettype none
module ptl_pretorque_latch_dir_confirm
  import ptl_pkg::*;
#(
  parameter int PT_W  = 16,
  parameter int SPD_W = 16
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  input  wire logic                    clk_en,
  // register port
  input  wire logic [3:0]              reg_addr,
  input  wire logic [15:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output var  logic [15:0]             reg_rdata,
  // pre-torque channels, same clock domain
  input  wire logic signed [PT_W-1:0]  pt_analog,
  input  wire logic signed [PT_W-1:0]  pt_serial,
  input  wire logic                    strobe_serial,
  // terminal pins, asynchronous
  input  wire logic                    strobe_terminal,
  input  wire logic                    run_up,
  input  wire logic                    run_down,
  // regulator side
  input  wire logic                    reg_release,
  output var  logic signed [PT_W-1:0]  feedforward_out,
  output var  logic                    feedforward_take,
  // speed path
  input  wire logic signed [SPD_W-1:0] speed_cmd,
  output var  logic signed [SPD_W-1:0] speed_out
);
  import ptl_pkg::*;

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [1:0] pt_source_reg;
  logic       hold_reg;
  logic [1:0] strb_src_reg;
  logic       pol_check_reg;

  // software settings, reset to the safe defaults
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pt_source_reg <= RST_PT_SOURCE;
      hold_reg      <= RST_HOLD;
      strb_src_reg  <= RST_STRB_SRC;
      pol_check_reg <= RST_POL_CHECK;
    end else if (clk_en && reg_wr) begin
      case (reg_addr)
        ADDR_PT_SOURCE: pt_source_reg <= reg_wdata[1:0];
        ADDR_HOLD:      hold_reg      <= reg_wdata[0];
        ADDR_STRB_SRC:  strb_src_reg  <= reg_wdata[1:0];
        ADDR_POL_CHECK: pol_check_reg <= reg_wdata[0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] pins_sync;
  ptl_sync2 #(.W(3)) u_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .d_in     ({strobe_terminal, run_up, run_down}),
    .q_out    (pins_sync)
  );
  logic strb_term_s;
  logic up_s;
  logic down_s;
  assign strb_term_s = pins_sync[2];
  assign up_s        = pins_sync[1];
  assign down_s      = pins_sync[0];

  // ---------------------------------------------------------------
  // source selection
  // ---------------------------------------------------------------
  logic signed [PT_W-1:0] pt_sel;
  logic                   latched_mode;
  logic                   strobe_sel;

  // unknown source codes behave as none
  always_comb begin
    case (pt_source_reg)
      PT_SRC_ANALOG: pt_sel = pt_analog;
      PT_SRC_SERIAL: pt_sel = pt_serial;
      default:       pt_sel = '0;
    endcase
  end

  // hold setting only matters when a source exists
  assign latched_mode = (pt_source_reg == PT_SRC_ANALOG || pt_source_reg == PT_SRC_SERIAL)
                        && (hold_reg == HOLD_LATCHED);

  // strobe source is only looked at in latched mode
  always_comb begin
    strobe_sel = 1'b0;
    if (latched_mode) begin
      case (strb_src_reg)
        STRB_TERMINAL: strobe_sel = strb_term_s;
        STRB_SERIAL:   strobe_sel = strobe_serial;
        default:       strobe_sel = 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // edge detection
  // ---------------------------------------------------------------
  logic strobe_d_reg;
  logic release_d_reg;
  logic strobe_rise;
  logic release_rise;

  // previous levels for rising-edge detect
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      strobe_d_reg  <= 1'b0;
      release_d_reg <= 1'b0;
    end else if (clk_en) begin
      strobe_d_reg  <= strobe_sel;
      release_d_reg <= reg_release;
    end
  end
  assign strobe_rise  = strobe_sel & ~strobe_d_reg;
  assign release_rise = reg_release & ~release_d_reg;

  // ---------------------------------------------------------------
  // feedforward latch
  // ---------------------------------------------------------------
  ptl_latch_e             latch_reg;
  logic signed [PT_W-1:0] held_reg;

  // a strobe in the same cycle as release wins: the fresh value is kept
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_reg <= PTL_EMPTY;
      held_reg  <= '0;
    end else if (clk_en) begin
      if (!latched_mode) begin
        latch_reg <= PTL_EMPTY;
        held_reg  <= '0;
      end else if (strobe_rise) begin
        latch_reg <= PTL_FULL;
        held_reg  <= pt_sel;
      end else begin
        case (latch_reg)
          PTL_FULL: begin
            if (release_rise) begin
              latch_reg <= PTL_CONSUMED;
            end
          end
          PTL_CONSUMED: begin
            latch_reg <= PTL_EMPTY;
            held_reg  <= '0;
          end
          default: latch_reg <= PTL_EMPTY;
        endcase
      end
    end
  end

  // regulator feed: captured value in latched mode, live channel otherwise
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      feedforward_out  <= '0;
      feedforward_take <= 1'b0;
    end else if (clk_en) begin
      feedforward_take <= 1'b0;
      if (!latched_mode) begin
        feedforward_out <= pt_sel;
      end else if (latch_reg == PTL_FULL && release_rise && !strobe_rise) begin
        feedforward_out  <= held_reg;
        feedforward_take <= 1'b1;
      end else if (latch_reg == PTL_CONSUMED) begin
        feedforward_out <= '0;
      end
    end
  end

  // ---------------------------------------------------------------
  // direction confirm
  // ---------------------------------------------------------------
  logic spd_pos;
  logic spd_neg;
  logic dir_bad;
  assign spd_pos = !speed_cmd[SPD_W-1] && (speed_cmd != '0);
  assign spd_neg = speed_cmd[SPD_W-1];
  // mismatched polarity against the active run input
  assign dir_bad = (up_s && spd_neg) || (down_s && spd_pos);

  // registered speed output; agreeing polarity passes unchanged
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      speed_out <= '0;
    end else if (clk_en) begin
      if (pol_check_reg == POL_CHECK_ON && dir_bad) begin
        speed_out <= '0;
      end else begin
        speed_out <= speed_cmd;
      end
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    case (reg_addr)
      ADDR_PT_SOURCE:  rd_mux = {14'h0000, pt_source_reg};
      ADDR_HOLD:       rd_mux = {15'h0000, hold_reg};
      ADDR_STRB_SRC:   rd_mux = {14'h0000, strb_src_reg};
      ADDR_POL_CHECK:  rd_mux = {15'h0000, pol_check_reg};
      ADDR_STATUS: begin
        rd_mux[STAT_FULL_BIT] = (latch_reg == PTL_FULL);
        rd_mux[STAT_HOLD_BIT] = latched_mode;
      end
      ADDR_HELD_VALUE: rd_mux = 16'(held_reg);
      ADDR_SPEED_OUT:  rd_mux = 16'(speed_out);
      default:         rd_mux = 16'h0000;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // handover edge, then one quiet cycle still in latched mode
  sequence s_handover;
    clk_en && latched_mode && latch_reg == PTL_FULL && release_rise && !strobe_rise
    ##1 clk_en && latched_mode && !strobe_rise;
  endsequence

  a_strobe_captures: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && latched_mode && strobe_rise |=> latch_reg == PTL_FULL && held_reg == $past(pt_sel))
    else $error("strobe edge did not capture channel");

  a_hold_steady: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    latch_reg == PTL_FULL && !strobe_rise && latched_mode |=> $stable(held_reg))
    else $error("held value changed without strobe edge");

  a_none_ignores_hold: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    pt_source_reg == PT_SRC_NONE |-> !latched_mode)
    else $error("latched mode active with no source");

  a_release_takes: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && latched_mode && latch_reg == PTL_FULL && release_rise && !strobe_rise
    |=> feedforward_take && feedforward_out == $past(held_reg))
    else $error("release did not hand over held value");

  a_consume_clears: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    s_handover |=> latch_reg == PTL_EMPTY && held_reg == '0 && feedforward_out == '0)
    else $error("latch not cleared after use");

  a_dir_zero: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && pol_check_reg && dir_bad |=> speed_out == '0)
    else $error("mismatched direction not forced to zero");

  a_dir_pass: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && pol_check_reg && up_s && !down_s && spd_pos |=> speed_out == $past(speed_cmd))
    else $error("agreeing up command altered");

  a_dir_pass_down: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && pol_check_reg && down_s && !up_s && spd_neg |=> speed_out == $past(speed_cmd))
    else $error("agreeing down command altered");

  a_check_off: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && !pol_check_reg |=> speed_out == $past(speed_cmd))
    else $error("speed altered with check off");

  a_pass_through: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    clk_en && !latched_mode |=> feedforward_out == $past(pt_sel))
    else $error("pass-through feedforward wrong");
endmodule : ptl_pretorque_latch_dir_confirm
`default_nettype wire

/* File: verification/ptl_car_ctl.sv */
`timescale 1ns/1ns
`default_nettype none
module ptl_car_ctl (
  input  wire logic               core_clk,
  output var  logic signed [15:0] pt_analog,
  output var  logic signed [15:0] pt_serial,
  output var  logic               strobe_serial,
  output var  logic               strobe_terminal,
  output var  logic               run_up,
  output var  logic               run_down,
  output var  logic               reg_release,
  output var  logic signed [15:0] speed_cmd
);
  // ---------------------------------------------------------------
  // idle levels of the car controller
  // ---------------------------------------------------------------
  initial begin
    pt_analog       = '0;
    pt_serial       = '0;
    strobe_serial   = 1'b0;
    strobe_terminal = 1'b0;
    run_up          = 1'b0;
    run_down        = 1'b0;
    reg_release     = 1'b0;
    speed_cmd       = '0;
  end

  // both channels together, one edge after the call
  task automatic set_chan(input logic signed [15:0] a, input logic signed [15:0] s);
    @(posedge core_clk);
    pt_analog <= a;
    pt_serial <= s;
  endtask : set_chan

  // channel steady across the strobe rise, then moved away on purpose
  // terminal strobe is held long enough to clear the pin synchroniser
  task automatic pulse(input logic term, input logic signed [15:0] v);
    set_chan(v, v);
    @(posedge core_clk);
    if (term) strobe_terminal <= 1'b1;
    else strobe_serial <= 1'b1;
    repeat (4) @(posedge core_clk);
    strobe_terminal <= 1'b0;
    strobe_serial   <= 1'b0;
    repeat (2) @(posedge core_clk);
    pt_analog <= ~v;
    pt_serial <= ~v;
  endtask : pulse

  // regulator release level
  task automatic set_release(input logic lvl);
    @(posedge core_clk);
    reg_release <= lvl;
  endtask : set_release

  // run pins and initial speed command
  task automatic set_run(input logic up, input logic dn, input logic signed [15:0] cmd);
    @(posedge core_clk);
    run_up    <= up;
    run_down  <= dn;
    speed_cmd <= cmd;
  endtask : set_run
endmodule : ptl_car_ctl
`default_nettype wire

/* File: verification/pretorque_latch_dir_confirm_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module pretorque_latch_dir_confirm_tb_top;
  import ptl_pkg::*;
  logic               core_clk, rst_b, reg_wr, reg_rd, strobe_serial, strobe_terminal;
  logic               run_up, run_down, reg_release, feedforward_take;
  logic [3:0]         reg_addr;
  logic [15:0]        reg_wdata, reg_rdata;
  logic signed [15:0] pt_analog, pt_serial, speed_cmd, speed_out, feedforward_out;
  int                 failures = 0;
  int                 checks = 0;
  // direction-confirm cases: enable, up, down, command, expected
  logic               d_on [6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
  logic               d_up [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  logic               d_dn [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  logic signed [15:0] d_cmd[6] = '{-16'sh5, 16'sh5, -16'sh5, -16'sh5, 16'sh5, -16'sh5};
  logic signed [15:0] d_exp[6] = '{-16'sh5, 16'sh5, -16'sh5, 16'sh0, 16'sh0, -16'sh5};
  logic [15:0]        pass_exp[4] = '{16'h0000, 16'h1234, 16'h4321, 16'h0000};

  // ---------------------------------------------------------------
  // clock, reset and instances
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  ptl_pretorque_latch_dir_confirm ptl_pretorque_latch_dir_confirm_i (
    .core_clk(core_clk), .rst_b(rst_b), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pt_analog(pt_analog), .pt_serial(pt_serial), .strobe_serial(strobe_serial),
    .strobe_terminal(strobe_terminal), .run_up(run_up), .run_down(run_down),
    .reg_release(reg_release), .feedforward_out(feedforward_out),
    .feedforward_take(feedforward_take), .speed_cmd(speed_cmd), .speed_out(speed_out));

  ptl_car_ctl ptl_car_ctl_i (
    .core_clk(core_clk), .pt_analog(pt_analog), .pt_serial(pt_serial),
    .strobe_serial(strobe_serial), .strobe_terminal(strobe_terminal), .run_up(run_up),
    .run_down(run_down), .reg_release(reg_release), .speed_cmd(speed_cmd));

  // ---------------------------------------------------------------
  // access and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd_chk

  // bounded wait for the one-cycle handover pulse
  task automatic wait_take();
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      #1;
      if (feedforward_take === 1'b1) break;
    end
  endtask : wait_take

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    // reset defaults and an unmapped place
    rd_chk(ADDR_PT_SOURCE, 16'h0000);
    rd_chk(ADDR_HOLD, 16'h0000);
    rd_chk(ADDR_STRB_SRC, 16'h0001);
    rd_chk(ADDR_POL_CHECK, 16'h0000);
    rd_chk(ADDR_STATUS, 16'h0000);
    rd_chk(4'hF, 16'h0000);
    // pass-through for every source code; the unused code 3 acts as none
    ptl_car_ctl_i.set_chan(16'sh1234, 16'sh4321);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_PT_SOURCE, 16'(s));
      repeat (3) @(posedge core_clk);
      #1 chk(feedforward_out, pass_exp[s]);
    end
    // hold selected with no source: strobe has no effect
    wr(ADDR_PT_SOURCE, 16'(PT_SRC_NONE));
    wr(ADDR_HOLD, 16'(HOLD_LATCHED));
    wr(ADDR_STRB_SRC, 16'(STRB_SERIAL));
    ptl_car_ctl_i.pulse(1'b0, 16'sh0777);
    rd_chk(ADDR_STATUS, 16'h0000);
    chk(feedforward_out, 16'h0000);
    // latched, serial strobe; later edge on the unselected terminal strobe
    wr(ADDR_PT_SOURCE, 16'(PT_SRC_SERIAL));
    ptl_car_ctl_i.pulse(1'b0, -16'sh0123);
    rd_chk(ADDR_HELD_VALUE, 16'hFEDD);
    ptl_car_ctl_i.pulse(1'b1, 16'sh0555);
    rd_chk(ADDR_HELD_VALUE, 16'hFEDD);
    rd_chk(ADDR_STATUS, (16'h1 << STAT_FULL_BIT) | (16'h1 << STAT_HOLD_BIT));
    // handover on release, then latch and value cleared
    ptl_car_ctl_i.set_release(1'b1);
    wait_take();
    chk({15'h0, feedforward_take}, 16'h0001);
    chk(feedforward_out, 16'hFEDD);
    @(posedge core_clk);
    #1 chk(feedforward_out, 16'h0000);
    ptl_car_ctl_i.set_release(1'b0);
    rd_chk(ADDR_HELD_VALUE, 16'h0000);
    rd_chk(ADDR_STATUS, 16'h1 << STAT_HOLD_BIT);
    // latched, terminal strobe through the pin synchroniser
    wr(ADDR_PT_SOURCE, 16'(PT_SRC_ANALOG));
    wr(ADDR_STRB_SRC, 16'(STRB_TERMINAL));
    ptl_car_ctl_i.pulse(1'b1, 16'sh2468);
    rd_chk(ADDR_HELD_VALUE, 16'h2468);
    // direction confirm table
    for (int k = 0; k < 6; k++) begin
      wr(ADDR_POL_CHECK, 16'(d_on[k]));
      ptl_car_ctl_i.set_run(d_up[k], d_dn[k], d_cmd[k]);
      repeat (5) @(posedge core_clk);
      #1 chk(speed_out, d_exp[k]);
      rd_chk(ADDR_SPEED_OUT, d_exp[k]);
    end
    // mid-run reset: a full latch and the source, hold and polarity-check settings go back to defaults
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    rd_chk(ADDR_PT_SOURCE, 16'h0000);
    rd_chk(ADDR_HOLD, 16'h0000);
    rd_chk(ADDR_POL_CHECK, 16'h0000);
    rd_chk(ADDR_STATUS, 16'h0000);
    rd_chk(ADDR_HELD_VALUE, 16'h0000);
    tally_and_finish();
  end
endmodule : pretorque_latch_dir_confirm_tb_top
`default_nettype wire
